// File: rtl/ocp_channel.sv
`timescale 1ns/1ps
module ocp_channel #(
  parameter int DW       = 16,
  parameter int CH_INDEX = 1,
  parameter int TCY_CLKS = ocp_pkg::TCY_CLKS
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // register port
  input  wire logic [2:0]    addr_i,
  input  wire logic [15:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [15:0]   rdata_o,
  // trigger and sync sources
  input  wire logic [31:0]   src_event_i,
  // fault sources
  input  wire logic          fault_pin_a_i,
  input  wire logic          fault_pin_b_i,
  input  wire logic [2:0]    comparator_i,
  // cascade partner
  input  wire logic          cascade_match_i,
  output logic               cmp_match_o,
  // compare_output_pin
  output logic               pin_o,
  output logic               pin_oe_o
);

  localparam int CMP_IDX = (CH_INDEX - 1) / 3;

  logic [15:0]        ctl1_ff, nxt_ctl1;
  logic [15:0]        ctl2_ff, nxt_ctl2;
  logic [DW-1:0]      pri_ff, nxt_pri;
  logic [DW-1:0]      sec_ff, nxt_sec;
  logic [DW-1:0]      per_ff, nxt_per;
  logic [DW-1:0]      pri_buf_ff, nxt_pri_buf;
  logic [DW-1:0]      sec_buf_ff, nxt_sec_buf;
  logic [1:0]         fine_buf_ff, nxt_fine_buf;
  logic [DW-1:0]      timer_ff, nxt_timer;
  logic [7:0]         phase_ff, nxt_phase;
  logic               trig_ff, nxt_trig;
  logic [2:0]         fstat_ff, nxt_fstat;
  logic               fault_ff, nxt_fault;
  ocp_pkg::ocp_state_t state_ff, nxt_state;
  logic               lvl_ff, nxt_lvl;
  logic               raw_ff, nxt_raw;
  logic               pend_ff, nxt_pend;
  logic [1:0]         cnt_ff, nxt_cnt;
  logic [15:0]        nxt_rdata;
  logic               nxt_pin, nxt_oe, nxt_cmatch;

  logic [2:0]  mode;
  logic        pwm, tick, per_match, casc_ok, mp, ms, rise;
  logic        trig_sel, ev, hold_clr, mode_wr, wr_flt;
  logic [4:0]  sel;
  logic [2:0]  fen, src_act, hit;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign mode     = ctl1_ff[ocp_pkg::M_MODE_LSB +: 3];
  assign pwm      = (mode == ocp_pkg::MD_PWM_EDGE) | (mode == ocp_pkg::MD_PWM_CTR);
  assign tick     = (phase_ff == 8'(TCY_CLKS - 1));
  assign per_match = tick & (timer_ff == per_ff);
  assign casc_ok  = ~ctl2_ff[ocp_pkg::F_CASC] | cascade_match_i;
  assign mp       = tick & casc_ok & (timer_ff == pri_buf_ff);
  assign ms       = tick & casc_ok & (timer_ff == sec_buf_ff);
  // edge PWM rises at period start, center PWM at primary match
  assign rise     = (mode == ocp_pkg::MD_PWM_EDGE) ? (tick & (timer_ff == '0)) : mp;
  assign trig_sel = ctl2_ff[ocp_pkg::F_TRIG];
  assign sel      = ctl2_ff[ocp_pkg::F_SEL_LSB +: 5];
  // no source and reserved codes never fire
  assign ev       = (sel != ocp_pkg::SEL_NONE) & (sel[4:1] != ocp_pkg::SEL_RSV) & src_event_i[sel];
  assign hold_clr = trig_sel & ~trig_ff;
  assign mode_wr  = wr_i & (addr_i == ocp_pkg::A_MODE) & (wdata_i[2:0] != mode);
  assign wr_flt   = wr_i & (addr_i == ocp_pkg::A_FLT);
  assign fen      = ctl1_ff[ocp_pkg::M_FEN_LSB +: 3];
  assign src_act  = {comparator_i[CMP_IDX], fault_pin_b_i, fault_pin_a_i};
  assign hit      = src_act & fen & {3{pwm}};

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_ctl1 = ctl1_ff;
    nxt_ctl2 = ctl2_ff;
    nxt_pri  = pri_ff;
    nxt_sec  = sec_ff;
    nxt_per  = per_ff;
    if (wr_i)
    begin
      case (addr_i)
        ocp_pkg::A_MODE: nxt_ctl1 = wdata_i & ocp_pkg::MODE_WMASK;
        ocp_pkg::A_FLT:  nxt_ctl2 = wdata_i & ocp_pkg::FLT_WMASK;
        ocp_pkg::A_PRI:  nxt_pri  = DW'(wdata_i);
        ocp_pkg::A_SEC:  nxt_sec  = DW'(wdata_i);
        ocp_pkg::A_PER:  nxt_per  = DW'(wdata_i);
        default:         ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctl1_ff <= ocp_pkg::MODE_RESET;
      ctl2_ff <= ocp_pkg::FLT_RESET;
      pri_ff  <= DW'(ocp_pkg::CMP_RESET);
      sec_ff  <= DW'(ocp_pkg::CMP_RESET);
      per_ff  <= DW'(ocp_pkg::PER_RESET);
    end
    else
    begin
      ctl1_ff <= nxt_ctl1;
      ctl2_ff <= nxt_ctl2;
      pri_ff  <= nxt_pri;
      sec_ff  <= nxt_sec;
      per_ff  <= nxt_per;
    end
  end

  // ----------------------------------------------------------------
  // duty buffers
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_pri_buf  = pri_buf_ff;
    nxt_sec_buf  = sec_buf_ff;
    nxt_fine_buf = fine_buf_ff;
    // pwm loads only at period end, other modes follow writes
    if (per_match | ~pwm)
    begin
      nxt_pri_buf  = pri_ff;
      nxt_sec_buf  = sec_ff;
      nxt_fine_buf = ctl2_ff[ocp_pkg::F_FINE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pri_buf_ff  <= DW'(ocp_pkg::CMP_RESET);
      sec_buf_ff  <= DW'(ocp_pkg::CMP_RESET);
      fine_buf_ff <= 2'h0;
    end
    else
    begin
      pri_buf_ff  <= nxt_pri_buf;
      sec_buf_ff  <= nxt_sec_buf;
      fine_buf_ff <= nxt_fine_buf;
    end
  end

  duty_hold_a: assert property (pwm && !per_match |=> $stable(pri_buf_ff) && $stable(sec_buf_ff))
    else $error("duty buffer changed inside period");

  // ----------------------------------------------------------------
  // time base and trigger flag
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_phase = tick ? 8'h00 : 8'(phase_ff + 8'h01);
    nxt_timer = timer_ff;
    if (hold_clr | (~trig_sel & ev))
      nxt_timer = '0;
    else if (per_match)
      nxt_timer = '0;
    else if (tick)
      nxt_timer = DW'(timer_ff + 1'b1);
    nxt_trig = trig_ff;
    if (wr_flt)
      nxt_trig = wdata_i[ocp_pkg::F_TSTAT];
    else if (ctl1_ff[ocp_pkg::M_TCLR_MODE] & ms)
      nxt_trig = 1'b0;
    if (trig_sel & ev)
      nxt_trig = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      phase_ff <= 8'h00;
      timer_ff <= '0;
      trig_ff  <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      timer_ff <= nxt_timer;
      trig_ff  <= nxt_trig;
    end
  end

  timer_held_a: assert property (trig_sel && !trig_ff |=> timer_ff == '0)
    else $error("timer ran while not triggered");
  trig_clear_a: assert property (trig_ff && ctl1_ff[ocp_pkg::M_TCLR_MODE] && ms
                                 && !wr_flt && !(trig_sel && ev) |=> !trig_ff)
    else $error("trigger flag not cleared on secondary match");
  trig_keep_a: assert property (trig_ff && !ctl1_ff[ocp_pkg::M_TCLR_MODE] && !wr_flt |=> trig_ff)
    else $error("trigger flag cleared by hardware");

  // ----------------------------------------------------------------
  // compare sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_lvl   = lvl_ff;
    if (mode_wr)
    begin
      nxt_state = (wdata_i[2:0] == ocp_pkg::MD_OFF) ? ocp_pkg::ST_OFF : ocp_pkg::ST_WAIT_P;
      nxt_lvl   = (wdata_i[2:0] == ocp_pkg::MD_SS_LO);
    end
    else if (pwm)
    begin
      if (rise)
        nxt_lvl = 1'b1;
      // clear wins: zero duty stays low, duty past period stays high
      if (ms)
        nxt_lvl = 1'b0;
    end
    else
    begin
      case (state_ff)
        ocp_pkg::ST_WAIT_P:
        begin
          if (mp)
          begin
            case (mode)
              ocp_pkg::MD_SS_HI:
              begin
                nxt_lvl   = 1'b1;
                nxt_state = ocp_pkg::ST_DONE;
              end
              ocp_pkg::MD_SS_LO:
              begin
                nxt_lvl   = 1'b0;
                nxt_state = ocp_pkg::ST_DONE;
              end
              ocp_pkg::MD_TOGGLE:
                nxt_lvl = ~lvl_ff;
              ocp_pkg::MD_DBL_ONE, ocp_pkg::MD_DBL_CONT:
              begin
                nxt_lvl   = ~lvl_ff;
                nxt_state = ocp_pkg::ST_WAIT_S;
              end
              default: ;
            endcase
          end
        end
        ocp_pkg::ST_WAIT_S:
        begin
          if (ms)
          begin
            nxt_lvl   = ~lvl_ff;
            nxt_state = (mode == ocp_pkg::MD_DBL_CONT) ? ocp_pkg::ST_WAIT_P : ocp_pkg::ST_DONE;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_ff <= ocp_pkg::ST_OFF;
      lvl_ff   <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      lvl_ff   <= nxt_lvl;
    end
  end

  sequence s_dbl_first;
    mode == ocp_pkg::MD_DBL_ONE && state_ff == ocp_pkg::ST_WAIT_P && mp && !mode_wr;
  endsequence
  sequence s_dbl_second;
    mode == ocp_pkg::MD_DBL_ONE && state_ff == ocp_pkg::ST_WAIT_S && ms && !mode_wr;
  endsequence
  single_pulse_a: assert property (s_dbl_first |=> state_ff == ocp_pkg::ST_WAIT_S)
    else $error("single pulse missed first edge");
  single_end_a: assert property (s_dbl_second |=> state_ff == ocp_pkg::ST_DONE && lvl_ff != $past(lvl_ff))
    else $error("single pulse did not finish");
  force_high_a: assert property (mode == ocp_pkg::MD_SS_HI && state_ff == ocp_pkg::ST_WAIT_P && mp
                                 && !mode_wr |=> lvl_ff && state_ff == ocp_pkg::ST_DONE)
    else $error("single compare did not drive high");
  disabled_a: assert property (state_ff == ocp_pkg::ST_OFF && !pwm |-> !lvl_ff)
    else $error("disabled channel output high");

  // ----------------------------------------------------------------
  // falling edge fine delay
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_raw  = raw_ff;
    nxt_pend = pend_ff;
    nxt_cnt  = cnt_ff;
    if (lvl_ff)
    begin
      nxt_raw  = 1'b1;
      nxt_pend = 1'b0;
    end
    else if (pend_ff)
    begin
      nxt_cnt = cnt_ff - 2'h1;
      if (cnt_ff == 2'h1)
      begin
        nxt_raw  = 1'b0;
        nxt_pend = 1'b0;
      end
    end
    else if (raw_ff)
    begin
      // one clock is a quarter of the instruction cycle
      if (fine_buf_ff == 2'h0)
        nxt_raw = 1'b0;
      else
      begin
        nxt_pend = 1'b1;
        nxt_cnt  = fine_buf_ff;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      raw_ff  <= 1'b0;
      pend_ff <= 1'b0;
      cnt_ff  <= 2'h0;
    end
    else
    begin
      raw_ff  <= nxt_raw;
      pend_ff <= nxt_pend;
      cnt_ff  <= nxt_cnt;
    end
  end

  fine_delay_a: assert property ($fell(lvl_ff) && raw_ff && !pend_ff && fine_buf_ff == 2'h2
                                 ##1 !lvl_ff [*2] |-> raw_ff ##1 !raw_ff)
    else $error("falling edge delay wrong");

  // ----------------------------------------------------------------
  // fault handling
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_fstat = fstat_ff;
    if (wr_i && addr_i == ocp_pkg::A_MODE)
      nxt_fstat = fstat_ff & wdata_i[ocp_pkg::M_FSTAT_LSB +: 3];
    nxt_fstat = nxt_fstat | hit;
    nxt_fault = fault_ff;
    if (!pwm)
      nxt_fault = 1'b0;
    else if (|hit)
      nxt_fault = 1'b1;
    else if (ctl2_ff[ocp_pkg::F_HOLD])
    begin
      if (fstat_ff == 3'h0)
        nxt_fault = 1'b0;
    end
    else if (per_match)
      nxt_fault = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      fstat_ff <= 3'h0;
      fault_ff <= 1'b0;
    end
    else
    begin
      fstat_ff <= nxt_fstat;
      fault_ff <= nxt_fault;
    end
  end

  fault_flag_a: assert property (hit[0] |=> fstat_ff[0] && fault_ff)
    else $error("fault source did not set its flag");
  fault_mode_a: assert property (!pwm |=> !fault_ff)
    else $error("fault active outside pwm");
  fault_hold_a: assert property (pwm && fault_ff && ctl2_ff[ocp_pkg::F_HOLD] && fstat_ff != 3'h0 |=> fault_ff)
    else $error("fault released before software clear");

  // ----------------------------------------------------------------
  // pin, read data, cascade
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_pin = fault_ff ? ctl2_ff[ocp_pkg::F_FLVL] : (raw_ff ^ ctl2_ff[ocp_pkg::F_INV]);
    nxt_oe  = ~ctl2_ff[ocp_pkg::F_TRIS] | (fault_ff & ctl2_ff[ocp_pkg::F_FDIR]);
    nxt_cmatch = (timer_ff == pri_buf_ff);
    nxt_rdata  = 16'h0000;
    if (rd_i)
    begin
      case (addr_i)
        ocp_pkg::A_MODE: nxt_rdata = ctl1_ff | {9'h000, fstat_ff, 4'h0};
        ocp_pkg::A_FLT:  nxt_rdata = ctl2_ff | {9'h000, trig_ff, 6'h00};
        ocp_pkg::A_PRI:  nxt_rdata = 16'(pri_ff);
        ocp_pkg::A_SEC:  nxt_rdata = 16'(sec_ff);
        ocp_pkg::A_PER:  nxt_rdata = 16'(per_ff);
        default:         nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pin_o       <= 1'b0;
      pin_oe_o    <= 1'b0;
      cmp_match_o <= 1'b0;
      rdata_o     <= 16'h0000;
    end
    else
    begin
      pin_o       <= nxt_pin;
      pin_oe_o    <= nxt_oe;
      cmp_match_o <= nxt_cmatch;
      rdata_o     <= nxt_rdata;
    end
  end

  fault_level_a: assert property (fault_ff |=> pin_o == $past(ctl2_ff[ocp_pkg::F_FLVL]))
    else $error("pin not at fault level");
  invert_out_a: assert property (!fault_ff |=> pin_o == $past(raw_ff ^ ctl2_ff[ocp_pkg::F_INV]))
    else $error("pin polarity wrong");
  tristate_pin_a: assert property (ctl2_ff[ocp_pkg::F_TRIS] && !fault_ff |=> !pin_oe_o)
    else $error("pin driven while tristated");
  fault_dir_a: assert property (fault_ff && ctl2_ff[ocp_pkg::F_FDIR] |=> pin_oe_o)
    else $error("fault did not force output");

endmodule : ocp_channel

// File: rtl/ocp_pkg.sv
package ocp_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] A_MODE = 3'h0;
  localparam logic [2:0] A_FLT  = 3'h1;
  localparam logic [2:0] A_PRI  = 3'h2;
  localparam logic [2:0] A_SEC  = 3'h3;
  localparam logic [2:0] A_PER  = 3'h4;

  // ----------------------------------------------------------------
  // compare_mode_control fields
  // ----------------------------------------------------------------
  localparam int M_MODE_LSB  = 0;
  localparam int M_TCLR_MODE = 3;
  localparam int M_FSTAT_LSB = 4;
  localparam int M_FEN_LSB   = 7;
  localparam logic [15:0] MODE_WMASK = 16'h3f8f;
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // compare_fault_trigger_control fields
  // ----------------------------------------------------------------
  localparam int F_SEL_LSB  = 0;
  localparam int F_TRIS     = 5;
  localparam int F_TSTAT    = 6;
  localparam int F_TRIG     = 7;
  localparam int F_CASC     = 8;
  localparam int F_FINE_LSB = 9;
  localparam int F_INV      = 12;
  localparam int F_FDIR     = 13;
  localparam int F_FLVL     = 14;
  localparam int F_HOLD     = 15;
  localparam logic [15:0] FLT_WMASK = 16'hf7bf;
  localparam logic [15:0] FLT_RESET = 16'h000c;

  // ----------------------------------------------------------------
  // compare and period reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] PER_RESET = 16'hffff;

  // ----------------------------------------------------------------
  // mode codes and source selector
  // ----------------------------------------------------------------
  localparam logic [2:0] MD_OFF      = 3'h0;
  localparam logic [2:0] MD_SS_HI    = 3'h1;
  localparam logic [2:0] MD_SS_LO    = 3'h2;
  localparam logic [2:0] MD_TOGGLE   = 3'h3;
  localparam logic [2:0] MD_DBL_ONE  = 3'h4;
  localparam logic [2:0] MD_DBL_CONT = 3'h5;
  localparam logic [2:0] MD_PWM_EDGE = 3'h6;
  localparam logic [2:0] MD_PWM_CTR  = 3'h7;
  localparam logic [4:0] SEL_NONE    = 5'h00;
  localparam logic [3:0] SEL_RSV     = 4'h8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 25;
  localparam int TCY_NS   = 100;
  localparam int TCY_CLKS = TCY_NS / CLK_NS;

  typedef enum logic [3:0] {
    ST_OFF    = 4'b0001,
    ST_WAIT_P = 4'b0010,
    ST_WAIT_S = 4'b0100,
    ST_DONE   = 4'b1000
  } ocp_state_t;

endpackage : ocp_pkg

// File: tb/ocp_far_side.sv
`timescale 1ns/1ps
module ocp_far_side (
  // clock
  input  wire logic        clk_i,
  // compare output pin
  input  wire logic        pin_o,
  input  wire logic        pin_oe_o,
  output logic             pin_lvl_o,
  // event, fault and cascade sources
  output logic [31:0]      src_event_o,
  output logic             fault_a_o,
  output logic             fault_b_o,
  output logic [2:0]       cmp_o,
  output logic             casc_o
);
  // ----------
  // pin load
  // ----------
  // weak pull-down once the pin is released
  assign pin_lvl_o = pin_oe_o ? pin_o : 1'b0;

  initial
  begin
    src_event_o = 32'h0;
    fault_a_o   = 1'b0;
    fault_b_o   = 1'b0;
    cmp_o       = 3'h0;
    casc_o      = 1'b0;
  end

  // ----------
  // sources
  // ----------
  // one-clock event on code n, raised after dly+1 clocks
  task automatic pulse(input int n, input int dly);
    repeat (dly + 1) @(posedge clk_i);
    src_event_o[n] <= 1'b1;
    @(posedge clk_i);
    src_event_o[n] <= 1'b0;
  endtask : pulse

  task automatic faults(input logic a, input logic b, input logic [2:0] c);
    @(posedge clk_i);
    fault_a_o <= a;
    fault_b_o <= b;
    cmp_o     <= c;
  endtask : faults

  task automatic cascade(input logic v);
    @(posedge clk_i);
    casc_o <= v;
  endtask : cascade
endmodule : ocp_far_side

// File: tb/ocp_channel_tb_top.sv
`timescale 1ns/1ps
module ocp_channel_tb_top;
  logic        clk_i;
  logic        reset_i;
  logic [2:0]  addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [15:0] rdata_o;
  logic [31:0] src_ev;
  logic        fa, fb, casc, pin, pin_oe, pin_lvl, cm;
  logic [2:0]  cmp;
  logic [15:0] exp_q[$];
  logic        rd_seen;
  logic [31:0] seed;
  int          n_fail;
  int          checked;

  ocp_channel i_ocp_channel (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_event_i(src_ev), .fault_pin_a_i(fa),
    .fault_pin_b_i(fb), .comparator_i(cmp), .cascade_match_i(casc), .cmp_match_o(cm),
    .pin_o(pin), .pin_oe_o(pin_oe));

  ocp_far_side i_ocp_far_side (.clk_i(clk_i), .pin_o(pin), .pin_oe_o(pin_oe), .pin_lvl_o(pin_lvl),
    .src_event_o(src_ev), .fault_a_o(fa), .fault_b_o(fb), .cmp_o(cmp), .casc_o(casc));

  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  // ----------
  // bus and checks
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic wm(input logic [15:0] d);
    wr(ocp_pkg::A_MODE, d);
  endtask : wm

  task automatic wf(input logic [15:0] d);
    wr(ocp_pkg::A_FLT, d);
  endtask : wf

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
  endtask : rd

  task automatic cfg(input logic [15:0] p, input logic [15:0] s, input logic [15:0] per);
    wr(ocp_pkg::A_PRI, p);
    wr(ocp_pkg::A_SEC, s);
    wr(ocp_pkg::A_PER, per);
  endtask : cfg

  task automatic chk_reg(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value rdata expected %h seen %h", e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic e);
    checked++;
    if (pin_lvl !== e)
    begin
      n_fail++;
      $display("wrong value pin expected %b seen %b", e, pin_lvl);
    end
  endtask : chk_pin

  // bounded wait for a pin level, then compare
  task automatic wait_pin(input logic e, input int lim);
    for (int i = 0; i < lim && pin_lvl !== e; i++) @(negedge clk_i);
    chk_pin(e);
  endtask : wait_pin

  task automatic hold_pin(input logic e, input int n);
    repeat (n) @(negedge clk_i);
    chk_pin(e);
  endtask : hold_pin

  // bounded wait for the compare match level, then compare
  task automatic chk_cm(input logic e, input int lim);
    for (int i = 0; i < lim && cm !== e; i++) @(negedge clk_i);
    checked++;
    if (cm !== e)
    begin
      n_fail++;
      $display("wrong value cmp_match expected %b seen %b", e, cm);
    end
  endtask : chk_cm

  // disable, then enter a mode from a known low pin
  task automatic mode(input logic [15:0] d);
    wm(16'h0000);
    wait_pin(1'b0, 8);
    wm(d);
  endtask : mode

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // read data stand one cycle after the strobe
  always @(posedge clk_i)
  begin
    if (rd_seen === 1'b1)
      chk_reg(exp_q.pop_front(), rdata_o);
    rd_seen <= rd_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end

  // ----------
  // tests
  // ----------
  initial
  begin
    reset_i = 1'b1;
    addr_i  = 3'h0;
    wdata_i = 16'h0000;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    rd_seen = 1'b0;
    seed    = 32'h7;
    n_fail  = 0;
    checked = 0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(ocp_pkg::A_MODE, ocp_pkg::MODE_RESET);
    rd(ocp_pkg::A_FLT, ocp_pkg::FLT_RESET);
    rd(ocp_pkg::A_PRI, ocp_pkg::CMP_RESET);
    rd(ocp_pkg::A_SEC, ocp_pkg::CMP_RESET);
    rd(ocp_pkg::A_PER, ocp_pkg::PER_RESET);
    wr(3'h5, 16'hffff);
    rd(3'h5, 16'h0000);
    repeat (4)
    begin
      seed = xs(seed);
      wr(ocp_pkg::A_PRI, seed[15:0]);
      rd(ocp_pkg::A_PRI, seed[15:0]);
    end
    wf(16'hfffe);
    rd(ocp_pkg::A_FLT, 16'hf7fe);
    wm(16'hffff);
    rd(ocp_pkg::A_MODE, 16'h3f8f);
    $display("test registers done");
    wm(16'h0000);
    // park the time base at zero so it never runs past the new period
    wf(16'h0080);
    cfg(16'h0003, 16'h0005, 16'h0007);
    wf(16'h0000);
    hold_pin(1'b0, 40);
    wf(16'h1000);
    wait_pin(1'b1, 8);
    wf(16'h1020);
    wait_pin(1'b0, 8);
    wf(16'h0000);
    $display("test pin control done");
    mode(16'h0002);
    wait_pin(1'b1, 8);
    wait_pin(1'b0, 40);
    hold_pin(1'b0, 48);
    mode(16'h0001);
    wait_pin(1'b1, 40);
    hold_pin(1'b1, 48);
    mode(16'h0003);
    wait_pin(1'b1, 40);
    wait_pin(1'b0, 40);
    wait_pin(1'b1, 40);
    mode(16'h0004);
    wait_pin(1'b1, 40);
    wait_pin(1'b0, 16);
    hold_pin(1'b0, 48);
    wf(16'h0400);
    mode(16'h0004);
    wait_pin(1'b1, 40);
    hold_pin(1'b1, 9);
    hold_pin(1'b0, 1);
    wf(16'h0000);
    mode(16'h0005);
    wait_pin(1'b1, 40);
    wait_pin(1'b0, 16);
    wait_pin(1'b1, 40);
    $display("test compare modes done");
    cfg(16'h0000, 16'h0003, 16'h0007);
    mode(16'h0006);
    wait_pin(1'b1, 40);
    wait_pin(1'b0, 20);
    mode(16'h0007);
    wm(16'h0000);
    cfg(16'h0002, 16'h0005, 16'h0007);
    wm(16'h0007);
    wait_pin(1'b1, 40);
    wait_pin(1'b0, 20);
    wr(ocp_pkg::A_SEC, 16'h0009);
    hold_pin(1'b1, 80);
    hold_pin(1'b1, 20);
    wf(16'h0080);
    cfg(16'h0000, 16'h0000, 16'h0000);
    wf(16'h00c0);
    hold_pin(1'b0, 60);
    $display("test pwm done");
    cfg(16'h0000, 16'h0009, 16'h0007);
    wf(16'h8000);
    mode(16'h0386);
    wait_pin(1'b1, 40);
    i_ocp_far_side.faults(1'b0, 1'b0, 3'b010);
    hold_pin(1'b1, 20);
    rd(ocp_pkg::A_MODE, 16'h0386);
    i_ocp_far_side.faults(1'b1, 1'b0, 3'b000);
    wait_pin(1'b0, 8);
    rd(ocp_pkg::A_MODE, 16'h0396);
    i_ocp_far_side.faults(1'b0, 1'b0, 3'b000);
    hold_pin(1'b0, 80);
    wm(16'h0386);
    wait_pin(1'b1, 40);
    wm(16'h0383);
    i_ocp_far_side.faults(1'b1, 1'b0, 3'b000);
    rd(ocp_pkg::A_MODE, 16'h0383);
    i_ocp_far_side.faults(1'b0, 1'b0, 3'b000);
    wm(16'h0386);
    wf(16'h6020);
    wait_pin(1'b0, 8);
    i_ocp_far_side.faults(1'b0, 1'b1, 3'b000);
    wait_pin(1'b1, 8);
    i_ocp_far_side.faults(1'b0, 1'b0, 3'b000);
    wait_pin(1'b0, 40);
    $display("test faults done");
    wm(16'h0000);
    cfg(16'h0003, 16'h0005, 16'h0007);
    wf(16'h0082);
    wm(16'h0009);
    hold_pin(1'b0, 60);
    chk_cm(1'b0, 0);
    rd(ocp_pkg::A_FLT, 16'h0082);
    i_ocp_far_side.pulse(2, 3);
    wait_pin(1'b1, 40);
    hold_pin(1'b1, 40);
    rd(ocp_pkg::A_FLT, 16'h0082);
    wf(16'h0090);
    i_ocp_far_side.pulse(16, 3);
    rd(ocp_pkg::A_FLT, 16'h0090);
    $display("test trigger done");
    wf(16'h0100);
    mode(16'h0001);
    chk_cm(1'b1, 40);
    hold_pin(1'b0, 40);
    i_ocp_far_side.cascade(1'b1);
    wait_pin(1'b1, 40);
    $display("test cascade done");
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule : ocp_channel_tb_top
